// *** testbench/sie_endec_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module sie_endec_props (
  input wire clk,
  input wire rst_n,
  input wire uart_transmit_input,
  input wire rate_program_select,
  input wire ir_receive_input,
  input wire uart_receive_output,
  input wire ir_transmit_output,
  input wire general_output_one,
  input wire general_output_two,
  input wire receive_activity_lamp,
  input wire transmit_activity_lamp
);
  reg [11:0] hi_cnt;
  reg [11:0] lo_cnt;
  reg [11:0] sel_cnt;
  always @(posedge clk) begin
    hi_cnt <= ir_transmit_output ? hi_cnt + 12'h001 : 12'h000;
    lo_cnt <= uart_receive_output ? 12'h000 : lo_cnt + 12'h001;
    sel_cnt <= rate_program_select ? sel_cnt + {11'h000, ~&sel_cnt} : 12'h000;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  property p_rst;
    disable iff (1'b0) !rst_n |=> uart_receive_output && !ir_transmit_output && !general_output_one
      && !general_output_two && !receive_activity_lamp && !transmit_activity_lamp;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle in reset");
  property p_quiet;
    $rose(ir_transmit_output) |-> sel_cnt < 12'h12C;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse while programming");
  property p_apply;
    $changed({general_output_one, general_output_two}) |-> !rate_program_select
      && ($past(rate_program_select, 3) || $past(rate_program_select, 4));
  endproperty
  a_apply: assert property (p_apply) else $error("outputs changed before select fell");
  property p_width;
    $fell(ir_transmit_output) |-> hi_cnt >= 12'h017 && hi_cnt <= 12'h900;
  endproperty
  a_width: assert property (p_width) else $error("pulse width out of range");
  property p_follow;
    $fell(ir_receive_input) |-> ##[3:5] !uart_receive_output;
  endproperty
  a_follow: assert property (p_follow) else $error("receive pulse not passed on");
  property p_stretch;
    $rose(uart_receive_output) |-> lo_cnt >= 12'h078;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretched bit too short");
  property p_rx_lamp;
    $fell(uart_receive_output) |-> ##[0:1] receive_activity_lamp;
  endproperty
  a_rx_lamp: assert property (p_rx_lamp) else $error("receive lamp not lit");
  property p_tx_lamp;
    $fell(uart_transmit_input) && !rate_program_select && !$past(rate_program_select, 4)
      |-> ##[1:5] transmit_activity_lamp;
  endproperty
  a_tx_lamp: assert property (p_tx_lamp) else $error("transmit lamp not lit");
endmodule
bind sie_endec sie_endec_props i_props (.clk(clk), .rst_n(rst_n), .uart_transmit_input(uart_transmit_input),
  .rate_program_select(rate_program_select), .ir_receive_input(ir_receive_input),
  .uart_receive_output(uart_receive_output), .ir_transmit_output(ir_transmit_output),
  .general_output_one(general_output_one), .general_output_two(general_output_two),
  .receive_activity_lamp(receive_activity_lamp), .transmit_activity_lamp(transmit_activity_lamp));
`default_nettype wire

// *** testbench/sie_endec_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module sie_endec_tb;
  reg clk;
  reg rst_n;
  reg sel = 1'b0;
  wire tx_line, ir_line, rx_out, ir_out, gpo1, gpo2, rx_lamp, tx_lamp;
  integer num_errors = 0, comparisons = 0, cycles = 0, pulses = 0, hi = 0, last_hi = 0, lo = 0, last_lo = 0;
  integer p0 = 0;
  integer d = 0;
  sie_host_model i_host (.clk(clk), .uart_line(tx_line), .ir_line(ir_line));
  // Reference raised so whole bytes fit a short run; rates scale with it
  sie_endec #(.CLK_HZ(200000000), .REF_HZ(50000000)) i_dut (
    .clk(clk), .rst_n(rst_n), .uart_transmit_input(tx_line), .rate_program_select(sel),
    .ir_receive_input(ir_line), .uart_receive_output(rx_out), .ir_transmit_output(ir_out),
    .general_output_one(gpo1), .general_output_two(gpo2), .receive_activity_lamp(rx_lamp),
    .transmit_activity_lamp(tx_lamp));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    hi <= ir_out ? hi + 1 : 0;
    if (!ir_out && hi != 0) begin
      last_hi <= hi;
      pulses <= pulses + 1;
    end
    lo <= rx_out ? 0 : lo + 1;
    if (rx_out && lo != 0) last_lo <= lo;
    if (cycles == 90000) begin
      num_errors = num_errors + 1;
      close_out;
    end
  end
  task close_out;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task chk(input [63:0] name, input ok, input [11:0] exp, input [11:0] got);
    begin
      comparisons = comparisons + 1;
      if (!ok) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s expected %0d seen %0d", name, exp, got);
      end
    end
  endtask
  task wait_clks(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task do_reset;
    begin
      rst_n = 1'b0;
      wait_clks(12);
      rst_n = 1'b1;
      wait_clks(1500);
    end
  endtask
  task chk_gpo(input [1:0] exp);
    chk("gpo", {gpo1, gpo2} === exp, {10'h000, exp}, {10'h000, gpo1, gpo2});
  endtask
  // Select held high well past the host wait before the byte goes out
  task prog_byte(input [7:0] ctl);
    begin
      sel = 1'b1;
      wait_clks(1500);
      p0 = pulses;
      i_host.send_byte(ctl);
      d = pulses - p0;
      chk("quiet", d == 0, 12'h000, d[11:0]);
    end
  endtask
  task tx_data(input integer w_min, input integer w_max);
    begin
      p0 = pulses;
      i_host.send_byte(8'h06);
      d = pulses - p0;
      chk("pulses", d == 7, 12'h007, d[11:0]);
      chk("width", last_hi >= w_min && last_hi <= w_max, w_min[11:0], last_hi[11:0]);
    end
  endtask
  task rx_data(input integer len, input integer l_min, input integer l_max);
    begin
      i_host.ir_pulse(len);
      chk("rx lamp", rx_lamp === 1'b1, 12'h001, {11'h000, rx_lamp});
      wait_clks(l_max + 20);
      chk("stretch", last_lo >= l_min && last_lo <= l_max, l_min[11:0], last_lo[11:0]);
    end
  endtask
  task t_default;
    begin
      chk("rx idle", rx_out === 1'b1, 12'h001, {11'h000, rx_out});
      chk_gpo(2'b00);
      tx_data(23, 25);
      rx_data(8, 1435, 1545);
      $display("end t_default");
    end
  endtask
  task t_prog_fixed;
    begin
      prog_byte(8'h35);
      chk("hold", gpo1 === 1'b0, 12'h000, {11'h000, gpo1});
      sel = 1'b0;
      wait_clks(8);
      chk_gpo(2'b10);
      i_host.bit_clks = 1152;
      tx_data(23, 25);
      rx_data(8, 1075, 1160);
      $display("end t_prog_fixed");
    end
  endtask
  task t_prog_short;
    begin
      prog_byte(8'hC2);
      sel = 1'b0;
      wait_clks(8);
      chk_gpo(2'b01);
      i_host.bit_clks = 384;
      tx_data(71, 73);
      rx_data(40, 355, 390);
      $display("end t_prog_short");
    end
  endtask
  task t_reset;
    begin
      prog_byte(8'h7F);
      sel = 1'b0;
      wait_clks(8);
      chk_gpo(2'b11);
      rx_data(8, 355, 390);
      do_reset;
      chk_gpo(2'b00);
      i_host.bit_clks = 1536;
      rx_data(8, 1435, 1545);
      $display("end t_reset");
    end
  endtask
  initial begin
    do_reset;
    t_default;
    t_prog_fixed;
    t_prog_short;
    t_reset;
    close_out;
  end
endmodule
`default_nettype wire

// *** testbench/sie_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sie_host_model (
  input wire clk,
  output reg uart_line,
  output reg ir_line
);
  integer bit_clks = 1536;
  initial begin
    uart_line = 1'b1;
    ir_line = 1'b1;
  end
  // Start zero, eight bits LSB first, one stop, no parity
  task send_byte(input [7:0] value);
    reg [9:0] frame;
    integer i;
    begin
      frame = {1'b1, value, 1'b0};
      for (i = 0; i < 10; i = i + 1) begin
        uart_line = frame[i];
        repeat (bit_clks) @(posedge clk);
        #1;
      end
    end
  endtask
  task ir_pulse(input integer len);
    begin
      ir_line = 1'b0;
      repeat (len) @(posedge clk);
      #1 ir_line = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// *** verilog/sie_consts.vh ***
`ifndef SIE_CONSTS_VH
`define SIE_CONSTS_VH

// Control byte layout, bit 7 unused
`define SIE_CTL_RATE_LSB 0
`define SIE_CTL_RATE_MSB 3
`define SIE_CTL_PULSE_BIT 4
`define SIE_CTL_GPO1_BIT 5
`define SIE_CTL_GPO2_BIT 6
`define SIE_CTL_W 8

// Reset values
`define SIE_RATE_DEFAULT 4'h6
`define SIE_PULSE_DEFAULT 1'b1
`define SIE_GPO_DEFAULT 1'b0

// Reference-clock divisors giving the 16x sample tick per rate code
`define SIE_DIV_W 8
`define SIE_DIV_0 8'h02
`define SIE_DIV_1 8'h04
`define SIE_DIV_2 8'h06
`define SIE_DIV_3 8'h0C
`define SIE_DIV_4 8'h10
`define SIE_DIV_5 8'h12
`define SIE_DIV_6 8'h18
`define SIE_DIV_7 8'h20
`define SIE_DIV_8 8'h30
`define SIE_DIV_9 8'h40
`define SIE_DIV_A 8'h60
`define SIE_DIV_B 8'h80
`define SIE_DIV_C 8'hC0

// Bit timing in sample ticks
`define SIE_PHASE_W 4
`define SIE_PHASE_LAST 4'hF
`define SIE_PHASE_MID 4'h7
`define SIE_BITS_LAST 3'h7
`define SIE_STRETCH_TICKS 5'h10
`define SIE_SHORT_TICKS 4'h3

// Fixed pulse length in ns, converted with the reference rate
`define SIE_FIXED_PULSE_NS 1627
`define SIE_NS_SCALE 10000000
`define SIE_HZ_SCALE 100
`define SIE_REF_NOMINAL_HZ 3686400

// Fifo shape
`define SIE_FIFO_DEPTH 16
`define SIE_FIFO_AW 4

`endif

// *** verilog/sie_endec.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sie_consts.vh"

// Notes on behaviour
// - Power-on runs at 9600 bit/s unprogrammed
// - Reset restores default state and rate
// - Select high: transmit character is control word
// - New settings apply when select falls
// - Control character: zero start, eight bits LSB-first
// - Bits 0-3 rate, 4 pulse, 5-6 outputs
// - General outputs follow their control bits
// - Pulse 1.627 us or 3/16 bit
// - Codes 0..C map to the rate table
// - Rates scale with the reference clock
// - Data mode shortens zero bits to pulses
// - Received pulse stretched to one full bit
// - Only zero bits pulse; one bits silent
// - Separate receive and transmit activity lamps
module sie_endec #(
  parameter CLK_HZ = 200000000,
  parameter REF_HZ = 3686400
) (
  input wire clk,
  input wire rst_n,
  input wire uart_transmit_input,
  input wire rate_program_select,
  input wire ir_receive_input,
  output reg uart_receive_output,
  output reg ir_transmit_output,
  output reg general_output_one,
  output reg general_output_two,
  output reg receive_activity_lamp,
  output reg transmit_activity_lamp
);
  // Fixed pulse in reference ticks, rounded up. Reckoned at the nominal reference
  // so it stays a fixed tick count and scales with REF_HZ like the rates
  // a fast reference would otherwise overflow the 4-bit count
  localparam integer FIXED_REF = (`SIE_FIXED_PULSE_NS * (`SIE_REF_NOMINAL_HZ / `SIE_HZ_SCALE) + `SIE_NS_SCALE - 1)
    / `SIE_NS_SCALE;
  localparam [3:0] FIXED_TICKS = FIXED_REF[3:0];
  // Shaper loads one extra count as the alignment slot, held low
  localparam [4:0] FIXED_LOAD = {1'b0, FIXED_TICKS} + 5'h01;
  localparam [4:0] SHORT_LOAD = {1'b0, `SIE_SHORT_TICKS} + 5'h01;

  localparam [3:0] P_IDLE = 4'h1;
  localparam [3:0] P_FRAME_START = 4'h2;
  localparam [3:0] P_DATA = 4'h4;
  localparam [3:0] P_STOP = 4'h8;

  // Input synchronisers
  // Reset levels match the idle pins, so no false edge follows reset
  reg tx_meta;
  reg tx_s;
  reg sel_meta;
  reg sel_s;
  reg rx_meta;
  reg rx_s;

  always @(posedge clk) begin
    if (!rst_n) begin
      tx_meta <= 1'b1;
      tx_s <= 1'b1;
      sel_meta <= 1'b0;
      sel_s <= 1'b0;
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      tx_meta <= uart_transmit_input;
      tx_s <= tx_meta;
      sel_meta <= rate_program_select;
      sel_s <= sel_meta;
      rx_meta <= ir_receive_input;
      rx_s <= rx_meta;
    end
  end

  // Active settings
  reg [3:0] rate_code;
  reg pulse_width_select;
  reg [`SIE_DIV_W-1:0] divisor;

  always @* begin
    case (rate_code)
      4'h0: divisor = `SIE_DIV_0;
      4'h1: divisor = `SIE_DIV_1;
      4'h2: divisor = `SIE_DIV_2;
      4'h3: divisor = `SIE_DIV_3;
      4'h4: divisor = `SIE_DIV_4;
      4'h5: divisor = `SIE_DIV_5;
      4'h6: divisor = `SIE_DIV_6;
      4'h7: divisor = `SIE_DIV_7;
      4'h8: divisor = `SIE_DIV_8;
      4'h9: divisor = `SIE_DIV_9;
      4'hA: divisor = `SIE_DIV_A;
      4'hB: divisor = `SIE_DIV_B;
      4'hC: divisor = `SIE_DIV_C;
      // Codes D..F never load; default only keeps the mux complete
      default: divisor = `SIE_DIV_6;
    endcase
  end

  wire ref_tick;
  wire sample_tick;

  // Divisors count reference periods, so every rate follows REF_HZ
  sie_rate_gen #(
    .CLK_HZ(CLK_HZ),
    .REF_HZ(REF_HZ)
  ) u_rate (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(divisor),
    .ref_tick(ref_tick),
    .sample_tick(sample_tick)
  );

  // Control character receiver
  // A byte cut short by select falling is dropped, never half applied
  reg [3:0] prg_state;
  reg [`SIE_PHASE_W-1:0] prg_phase;
  reg [2:0] prg_bits;
  reg [`SIE_CTL_W-1:0] prg_shift;
  reg [`SIE_CTL_W-1:0] setup_control_byte;
  reg prg_pending;
  reg sel_prev;
  wire prg_end = sel_prev && !sel_s;

  always @(posedge clk) begin
    if (!rst_n) begin
      prg_state <= P_IDLE;
      prg_phase <= 4'h0;
      prg_bits <= 3'h0;
      prg_shift <= 8'h00;
      setup_control_byte <= 8'h00;
      prg_pending <= 1'b0;
      sel_prev <= 1'b0;
      rate_code <= `SIE_RATE_DEFAULT;
      pulse_width_select <= `SIE_PULSE_DEFAULT;
      general_output_one <= `SIE_GPO_DEFAULT;
      general_output_two <= `SIE_GPO_DEFAULT;
    end else begin
      sel_prev <= sel_s;
      if (prg_end) begin
        prg_state <= P_IDLE;
        if (prg_pending) begin
          prg_pending <= 1'b0;
          // Unlisted codes keep the old rate rather than guess one
          if (setup_control_byte[`SIE_CTL_RATE_MSB:`SIE_CTL_RATE_LSB] <= 4'hC) begin
            rate_code <= setup_control_byte[`SIE_CTL_RATE_MSB:`SIE_CTL_RATE_LSB];
          end
          pulse_width_select <= setup_control_byte[`SIE_CTL_PULSE_BIT];
          general_output_one <= setup_control_byte[`SIE_CTL_GPO1_BIT];
          general_output_two <= setup_control_byte[`SIE_CTL_GPO2_BIT];
        end
      end else if (!sel_s) begin
        prg_state <= P_IDLE;
      end else if (sample_tick) begin
        case (prg_state)
          P_IDLE: begin
            prg_phase <= 4'h0;
            if (!tx_s) begin
              prg_state <= P_FRAME_START;
            end
          end
          P_FRAME_START: begin
            prg_phase <= prg_phase + 4'h1;
            if (prg_phase == `SIE_PHASE_MID) begin
              prg_phase <= 4'h0;
              prg_bits <= 3'h0;
              prg_state <= tx_s ? P_IDLE : P_DATA;
            end
          end
          P_DATA: begin
            prg_phase <= prg_phase + 4'h1;
            if (prg_phase == `SIE_PHASE_LAST) begin
              prg_shift <= {tx_s, prg_shift[`SIE_CTL_W-1:1]};
              prg_bits <= prg_bits + 3'h1;
              if (prg_bits == `SIE_BITS_LAST) begin
                prg_state <= P_STOP;
              end
            end
          end
          P_STOP: begin
            prg_phase <= prg_phase + 4'h1;
            if (prg_phase == `SIE_PHASE_LAST) begin
              prg_state <= P_IDLE;
              // A low stop bit means a broken frame; keep the old byte
              if (tx_s) begin
                setup_control_byte <= prg_shift;
                prg_pending <= 1'b1;
              end
            end
          end
          default: prg_state <= P_IDLE;
        endcase
      end
    end
  end

  // Zero-bit detector, one pulse request per low bit period
  reg tx_prev;
  reg [`SIE_PHASE_W-1:0] tx_phase;
  reg req_valid;
  reg req_width;
  wire req_ready;

  always @(posedge clk) begin
    if (!rst_n) begin
      tx_prev <= 1'b1;
      tx_phase <= 4'h0;
      req_valid <= 1'b0;
      req_width <= 1'b0;
      transmit_activity_lamp <= 1'b0;
    end else begin
      transmit_activity_lamp <= !tx_s && !sel_s;
      // A request still waiting on a full fifo stalls; later bits are dropped
      if (req_valid && req_ready) begin
        req_valid <= 1'b0;
      end
      if (sample_tick) begin
        tx_prev <= tx_s;
        if (sel_s || tx_s) begin
          tx_phase <= 4'h0;
        end else if (tx_prev || tx_phase == `SIE_PHASE_LAST) begin
          tx_phase <= 4'h0;
          if (!req_valid || req_ready) begin
            req_valid <= 1'b1;
            req_width <= pulse_width_select;
          end
        end else begin
          tx_phase <= tx_phase + 4'h1;
        end
      end
    end
  end

  wire pul_valid;
  wire pul_width;
  wire pul_ready;

  sie_fifo #(
    .WIDTH(1),
    .DEPTH(`SIE_FIFO_DEPTH),
    .AW(`SIE_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(req_valid),
    .in_ready(req_ready),
    .in_data(req_width),
    .out_valid(pul_valid),
    .out_ready(pul_ready),
    .out_data(pul_width)
  );

  // Pulse shaper; the extra count aligns the start to a tick edge
  reg [4:0] pul_cnt;
  reg pul_unit;
  wire pul_tick = pul_unit ? ref_tick : sample_tick;
  assign pul_ready = (pul_cnt == 5'h00);
  wire pul_slot = (pul_cnt == (pul_unit ? FIXED_LOAD : SHORT_LOAD));

  always @(posedge clk) begin
    if (!rst_n) begin
      pul_cnt <= 5'h00;
      pul_unit <= 1'b0;
      ir_transmit_output <= 1'b0;
    end else begin
      if (pul_ready && pul_valid) begin
        pul_unit <= pul_width;
        pul_cnt <= pul_width ? FIXED_LOAD : SHORT_LOAD;
      end else if (pul_tick && pul_cnt != 5'h00) begin
        pul_cnt <= pul_cnt - 5'h01;
      end
      ir_transmit_output <= (pul_cnt != 5'h00) && !pul_slot;
    end
  end

  // Receive stretcher, retriggered by each pulse start
  // A pulse shorter than one clock may slip past the synchroniser
  reg rx_prev;
  reg [4:0] rx_cnt;

  always @(posedge clk) begin
    if (!rst_n) begin
      rx_prev <= 1'b1;
      rx_cnt <= 5'h00;
      uart_receive_output <= 1'b1;
      receive_activity_lamp <= 1'b0;
    end else begin
      rx_prev <= rx_s;
      if (rx_prev && !rx_s) begin
        rx_cnt <= `SIE_STRETCH_TICKS;
      end else if (sample_tick && rx_cnt != 5'h00) begin
        rx_cnt <= rx_cnt - 5'h01;
      end
      uart_receive_output <= (rx_cnt == 5'h00);
      receive_activity_lamp <= (rx_cnt != 5'h00);
    end
  end
endmodule

`default_nettype wire

// *** verilog/sie_fifo.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sie_consts.vh"

module sie_fifo #(
  parameter WIDTH = 1,
  parameter DEPTH = `SIE_FIFO_DEPTH,
  parameter AW = `SIE_FIFO_AW
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL = DEPTH;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count != FULL);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign out_data = mem[rd_ptr];

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// *** verilog/sie_rate_gen.v ***
`timescale 1ns/1ps
`default_nettype none
`include "sie_consts.vh"

module sie_rate_gen #(
  parameter CLK_HZ = 200000000,
  parameter REF_HZ = 3686400
) (
  input wire clk,
  input wire rst_n,
  input wire [`SIE_DIV_W-1:0] divisor,
  output reg ref_tick,
  output reg sample_tick
);
  localparam [31:0] REF_INC = REF_HZ;
  localparam [31:0] CLK_MOD = CLK_HZ;

  reg [31:0] acc;
  reg [`SIE_DIV_W-1:0] div_cnt;
  wire [31:0] acc_sum = acc + REF_INC;
  wire div_end = (div_cnt >= divisor - 8'h01);

  // Phase accumulator keeps the reference rate exact without a second clock
  always @(posedge clk) begin
    if (!rst_n) begin
      acc <= 32'h0;
      ref_tick <= 1'b0;
      div_cnt <= 8'h00;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (acc_sum >= CLK_MOD) begin
        acc <= acc_sum - CLK_MOD;
        ref_tick <= 1'b1;
      end else begin
        acc <= acc_sum;
        ref_tick <= 1'b0;
      end
      if (ref_tick) begin
        if (div_end) begin
          div_cnt <= 8'h00;
          sample_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire
